// >>> rtl/rtcfl_pkg.sv
package rtcfl_pkg;

    // ----------------------------------------
    // clocking
    // ----------------------------------------
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned CLK_MHZ = 25;
    localparam int unsigned OSC_HZ = 32768;
    // accumulator ticks at twice the oscillator so bit 0 is a 32768 Hz square
    localparam int unsigned ACC_W = 26;
    localparam logic [25:0] TICK_INC = 26'(2 * OSC_HZ);
    localparam logic [25:0] TICK_MOD = 26'(CLK_HZ);

    // ----------------------------------------
    // prescaler taps (counts ticks at 65536 Hz)
    // ----------------------------------------
    localparam int unsigned PRE_W = 16;
    localparam int unsigned PRE_BIT_32K = 0;
    localparam int unsigned PRE_BIT_1K = 5;
    localparam int unsigned PRE_BIT_1HZ = 15;
    localparam logic [15:0] MASK_4K = 16'h000F;
    localparam logic [15:0] MASK_64 = 16'h03FF;
    localparam logic [15:0] MASK_2HZ = 16'h7FFF;
    localparam logic [15:0] MASK_1HZ = 16'hFFFF;
    localparam logic [5:0] SEC_LAST = 6'h3B;

    // ----------------------------------------
    // release times of the interrupt pin
    // ----------------------------------------
    localparam int unsigned REL_LONG_US = 500_000;
    localparam int unsigned REL_SHORT_US = 7813;
    localparam int unsigned REL_LONG_CYC = REL_LONG_US * CLK_MHZ;
    localparam int unsigned REL_SHORT_CYC = REL_SHORT_US * CLK_MHZ;
    localparam int unsigned REL_W = 24;

    // ----------------------------------------
    // register map (index, byte address = index * 4)
    // ----------------------------------------
    localparam logic [3:0] IDX_TMR_LO = 4'hB;
    localparam logic [3:0] IDX_TMR_HI = 4'hC;
    localparam logic [3:0] IDX_EXT = 4'hD;
    localparam logic [3:0] IDX_FLAG = 4'hE;
    localparam logic [3:0] IDX_CTRL = 4'hF;

    localparam int unsigned EXT_WADA = 6;
    localparam int unsigned EXT_UPDATE_PERIOD_SEL = 5;
    localparam int unsigned EXT_RUN = 4;
    localparam int unsigned EXT_FSEL = 2;
    localparam int unsigned EXT_TSEL = 0;

    localparam int unsigned FLG_UPD = 5;
    localparam int unsigned FLG_TMR = 4;
    localparam int unsigned FLG_ALM = 3;
    localparam int unsigned FLG_EVT = 2;
    localparam int unsigned FLG_LOSS = 1;
    localparam int unsigned FLG_COMP = 0;

    localparam int unsigned CTL_CSEL = 6;
    localparam int unsigned CTL_UIE = 5;
    localparam int unsigned CTL_TIE = 4;
    localparam int unsigned CTL_AIE = 3;
    localparam int unsigned CTL_EIE = 2;
    localparam int unsigned CTL_CRST = 0;

    localparam logic [7:0] EXT_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h40;
    localparam logic [3:0] TMR_HI_RST = 4'h0;
    localparam logic [7:0] TMR_LO_RST = 8'h00;
    localparam logic [7:0] EXT_WMASK = 8'h7F;
    localparam logic [7:0] CTRL_WMASK = 8'hFD;

    // half-second counts of the compensation interval
    localparam logic [6:0] COMP_HALF_0P5 = 7'h01;
    localparam logic [6:0] COMP_HALF_2 = 7'h04;
    localparam logic [6:0] COMP_HALF_10 = 7'h14;
    localparam logic [6:0] COMP_HALF_30 = 7'h3C;

    // ----------------------------------------
    // selector codes
    // ----------------------------------------
    typedef enum logic [1:0] {CLKOUT_32K, CLKOUT_1K, CLKOUT_1HZ, CLKOUT_32K_B} rtcfl_clkout_t;
    typedef enum logic [1:0] {SRC_4K, SRC_64, SRC_SEC, SRC_MIN} rtcfl_src_t;
    typedef enum logic [1:0] {COMP_0P5, COMP_2, COMP_10, COMP_30} rtcfl_comp_t;

endpackage

// >>> rtl/rtcfl_tick.sv
`timescale 1ns/1ps
// fractional divider: one-cycle pulse at INC/MOD of the clock rate
module rtcfl_tick #(
    parameter int unsigned W = 26,
    parameter logic [W-1:0] INC = '0,
    parameter logic [W-1:0] MOD = '1
) (
    // clock and reset
    input wire logic sysClk,
    input wire logic rstN,
    // output
    output logic tick
);

    logic [W-1:0] acc;
    logic [W:0] sum;

    assign sum = {1'b0, acc} + {1'b0, INC};

    always_ff @(posedge sysClk or negedge rstN) begin
        if (!rstN) begin
            acc <= '0;
            tick <= 1'b0;
        end else if (sum >= {1'b0, MOD}) begin
            acc <= W'(sum - {1'b0, MOD});
            tick <= 1'b1;
        end else begin
            acc <= W'(sum);
            tick <= 1'b0;
        end
    end

endmodule

// >>> rtl/rtcfl_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser; a level is accepted once stages 2 and 3 agree
module rtcfl_sync #(
    parameter int unsigned W = 4
) (
    // clock and reset
    input wire logic sysClk,
    input wire logic rstN,
    // asynchronous inputs
    input wire logic [W-1:0] din,
    // synchronised level and rising-edge pulse
    output logic [W-1:0] level,
    output logic [W-1:0] rise
);

    logic [W-1:0] st1;
    logic [W-1:0] st2;
    logic [W-1:0] st3;

    always_ff @(posedge sysClk or negedge rstN) begin
        if (!rstN) begin
            st1 <= '0;
            st2 <= '0;
            st3 <= '0;
            level <= '0;
            rise <= '0;
        end else begin
            st1 <= din;
            st2 <= st1;
            st3 <= st2;
            for (int i = 0; i < W; i++) begin
                if (st2[i] == st3[i]) begin
                    level[i] <= st3[i];
                end
            end
            rise <= ~level & st3 & st2;
        end
    end

endmodule

// >>> rtl/rtcfl_core.sv
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
// Notes on behaviour
// - period select 0 gives second updates, 1 minute; pin releases after 500/7.813 ms.
// - writing run bit 1 starts the countdown from the preset value.
// - writing run bit 0 stops the countdown; no more timer events.
// - clock-out select 00 32768 Hz, 01 1024 Hz, 10 1 Hz, 11 32768 Hz.
// - countdown source 00 4096 Hz, 01 64 Hz, 10 seconds, 11 minutes.
// - flag bits 5..0 update, timer, alarm, event, loss, comp-stop; 7:6 zero.
// - update flag sets on update event, held until host writes 0.
// - timer flag sets on countdown event, held until host writes 0.
// - alarm flag sets on alarm match, held until 0 written.
// - event flag sets on event input, held until cleared, resets to 0.
// - data-loss flag sets on loss, reads 1 after reset, write 1 ignored.
// - comp-stop flag sets when compensation halts, 1 after reset, write 1 ignored.
// - control holds comp interval 7:6, enables 5..2, bit 1 zero, clock reset 0.
// - comp interval 00 0.5 s, 01 2 s default, 10 10 s, 11 30 s.
// - pin low on update event only with enable; enable 0 releases it.
// - update assertion releases by itself without any flag write.
// - pin is OR of update, timer, alarm sources each gated by enable.
module rtcfl_core #(
    parameter int unsigned RELEASE_LONG_CYC = rtcfl_pkg::REL_LONG_CYC,
    parameter int unsigned RELEASE_SHORT_CYC = rtcfl_pkg::REL_SHORT_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // event sources from outside the clock domain
    input wire logic alarmMatch,
    input wire logic eventIn,
    input wire logic dataLossIn,
    input wire logic compStopIn,
    // interrupt pin, open drain, active low
    output logic intPinOut,
    output logic intPinOe,
    // other outputs
    output logic clock_out_pin,
    output logic compStrobe,
    output logic clockResetActive,
    output logic alarmDaySel
);

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] extension_config;
    logic [7:0] interrupt_and_comp_control;
    logic [5:0] event_flags;
    logic [7:0] presetLo;
    logic [3:0] presetHi;
    logic ack;
    logic wrStb;
    logic [3:0] regIdx;
    logic [7:0] wrByte;

    logic update_period_sel;
    logic countdown_run;
    logic [1:0] clkout_freq_sel;
    logic [1:0] countdown_source_sel;
    logic [1:0] comp_interval_sel;
    logic update_irq_enable;
    logic countdown_irq_enable;
    logic alarm_irq_enable;
    logic event_irq_enable;

    assign update_period_sel = extension_config[rtcfl_pkg::EXT_UPDATE_PERIOD_SEL];
    assign countdown_run = extension_config[rtcfl_pkg::EXT_RUN];
    assign clkout_freq_sel = extension_config[rtcfl_pkg::EXT_FSEL +: 2];
    assign countdown_source_sel = extension_config[rtcfl_pkg::EXT_TSEL +: 2];
    assign comp_interval_sel = interrupt_and_comp_control[rtcfl_pkg::CTL_CSEL +: 2];
    assign update_irq_enable = interrupt_and_comp_control[rtcfl_pkg::CTL_UIE];
    assign countdown_irq_enable = interrupt_and_comp_control[rtcfl_pkg::CTL_TIE];
    assign alarm_irq_enable = interrupt_and_comp_control[rtcfl_pkg::CTL_AIE];
    assign event_irq_enable = interrupt_and_comp_control[rtcfl_pkg::CTL_EIE];
    assign clockResetActive = interrupt_and_comp_control[rtcfl_pkg::CTL_CRST];
    assign alarmDaySel = extension_config[rtcfl_pkg::EXT_WADA];

    // ----------------------------------------
    // bus slave: one wait state, answer on the second cycle
    // ----------------------------------------
    assign regIdx = avs_address[5:2];
    assign wrByte = avs_writedata[7:0];
    assign avs_waitrequest = (avs_read | avs_write) & ~ack;
    assign wrStb = avs_write & ack & avs_byteenable[0];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read | avs_write) & ~ack;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= '0;
        end else if (avs_read && !ack) begin
            case (regIdx)
                rtcfl_pkg::IDX_TMR_LO: avs_readdata <= {24'h000000, presetLo};
                rtcfl_pkg::IDX_TMR_HI: avs_readdata <= {28'h0000000, presetHi};
                rtcfl_pkg::IDX_EXT: avs_readdata <= {24'h000000, extension_config};
                rtcfl_pkg::IDX_FLAG: avs_readdata <= {26'h0000000, event_flags};
                rtcfl_pkg::IDX_CTRL: begin
                    avs_readdata <= {24'h000000, interrupt_and_comp_control};
                end
                default: avs_readdata <= '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            extension_config <= rtcfl_pkg::EXT_RST;
            interrupt_and_comp_control <= rtcfl_pkg::CTRL_RST;
            presetLo <= rtcfl_pkg::TMR_LO_RST;
            presetHi <= rtcfl_pkg::TMR_HI_RST;
        end else if (wrStb) begin
            case (regIdx)
                rtcfl_pkg::IDX_TMR_LO: presetLo <= wrByte;
                rtcfl_pkg::IDX_TMR_HI: presetHi <= wrByte[3:0];
                rtcfl_pkg::IDX_EXT: extension_config <= wrByte & rtcfl_pkg::EXT_WMASK;
                rtcfl_pkg::IDX_CTRL: begin
                    interrupt_and_comp_control <= wrByte & rtcfl_pkg::CTRL_WMASK;
                end
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // time base
    // ----------------------------------------
    logic tick;
    logic [15:0] pre;
    logic [5:0] secCnt;
    logic secEv;
    logic minEv;
    logic halfEv;
    logic ev4k;
    logic ev64;

    rtcfl_tick #(
        .W(rtcfl_pkg::ACC_W),
        .INC(rtcfl_pkg::TICK_INC),
        .MOD(rtcfl_pkg::TICK_MOD)
    ) u_tick (
        .sysClk(sys_clk),
        .rstN(rst_n),
        .tick(tick)
    );

    assign ev4k = tick && ((pre & rtcfl_pkg::MASK_4K) == rtcfl_pkg::MASK_4K);
    assign ev64 = tick && ((pre & rtcfl_pkg::MASK_64) == rtcfl_pkg::MASK_64);
    assign halfEv = tick && ((pre & rtcfl_pkg::MASK_2HZ) == rtcfl_pkg::MASK_2HZ);
    assign secEv = tick && (pre == rtcfl_pkg::MASK_1HZ);
    assign minEv = secEv && (secCnt == rtcfl_pkg::SEC_LAST);

    // clock reset holds the sub-second chain and stops the clock
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre <= '0;
            secCnt <= '0;
        end else if (clockResetActive) begin
            pre <= '0;
        end else if (tick) begin
            pre <= pre + 16'h0001;
            if (secEv) begin
                secCnt <= minEv ? 6'h00 : secCnt + 6'h01;
            end
        end
    end

    // ----------------------------------------
    // clock output
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            clock_out_pin <= 1'b0;
        end else begin
            case (rtcfl_pkg::rtcfl_clkout_t'(clkout_freq_sel))
                rtcfl_pkg::CLKOUT_1K: clock_out_pin <= pre[rtcfl_pkg::PRE_BIT_1K];
                rtcfl_pkg::CLKOUT_1HZ: clock_out_pin <= pre[rtcfl_pkg::PRE_BIT_1HZ];
                default: clock_out_pin <= pre[rtcfl_pkg::PRE_BIT_32K];
            endcase
        end
    end

    // ----------------------------------------
    // compensation interval strobe
    // ----------------------------------------
    logic [6:0] compCnt;
    logic [6:0] compLast;

    always_comb begin
        case (rtcfl_pkg::rtcfl_comp_t'(comp_interval_sel))
            rtcfl_pkg::COMP_0P5: compLast = rtcfl_pkg::COMP_HALF_0P5;
            rtcfl_pkg::COMP_2: compLast = rtcfl_pkg::COMP_HALF_2;
            rtcfl_pkg::COMP_10: compLast = rtcfl_pkg::COMP_HALF_10;
            default: compLast = rtcfl_pkg::COMP_HALF_30;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            compCnt <= '0;
            compStrobe <= 1'b0;
        end else begin
            compStrobe <= 1'b0;
            if (halfEv) begin
                if (compCnt + 7'h01 >= compLast) begin
                    compCnt <= '0;
                    compStrobe <= 1'b1;
                end else begin
                    compCnt <= compCnt + 7'h01;
                end
            end
        end
    end

    // ----------------------------------------
    // countdown timer
    // ----------------------------------------
    logic [11:0] tmrCnt;
    logic runLast;
    logic srcEv;
    logic tmrEv;

    always_comb begin
        case (rtcfl_pkg::rtcfl_src_t'(countdown_source_sel))
            rtcfl_pkg::SRC_4K: srcEv = ev4k;
            rtcfl_pkg::SRC_64: srcEv = ev64;
            rtcfl_pkg::SRC_SEC: srcEv = secEv;
            default: srcEv = minEv;
        endcase
    end

    assign tmrEv = countdown_run && runLast && srcEv && (tmrCnt == 12'h001);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tmrCnt <= '0;
            runLast <= 1'b0;
        end else begin
            runLast <= countdown_run;
            if (countdown_run && !runLast) begin
                tmrCnt <= {presetHi, presetLo};
            end else if (countdown_run && srcEv) begin
                if (tmrCnt == 12'h001) begin
                    tmrCnt <= {presetHi, presetLo};
                end else if (tmrCnt != 12'h000) begin
                    tmrCnt <= tmrCnt - 12'h001;
                end
            end
        end
    end

    // ----------------------------------------
    // external event inputs
    // ----------------------------------------
    logic [3:0] extLevel;
    logic [3:0] extRise;

    rtcfl_sync #(
        .W(4)
    ) u_sync (
        .sysClk(sys_clk),
        .rstN(rst_n),
        .din({alarmMatch, eventIn, dataLossIn, compStopIn}),
        .level(extLevel),
        .rise(extRise)
    );

    // ----------------------------------------
    // flags: set wins over a clear in the same cycle
    // ----------------------------------------
    logic updEv;
    logic [5:0] setVec;
    logic [5:0] clrVec;

    assign updEv = update_period_sel ? minEv : secEv;
    assign setVec = {updEv, tmrEv, extRise[3], extRise[2], extRise[1], extRise[0]};
    assign clrVec = (wrStb && regIdx == rtcfl_pkg::IDX_FLAG) ? ~wrByte[5:0] : 6'h00;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            event_flags <= {4'h0, 2'h3};
        end else begin
            event_flags <= (event_flags & ~clrVec) | setVec;
        end
    end

    // ----------------------------------------
    // interrupt pin
    // ----------------------------------------
    logic [23:0] updRel;
    logic [23:0] tmrRel;
    logic updAct;
    logic tmrAct;
    logic almAct;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            updAct <= 1'b0;
            updRel <= '0;
        end else if (!update_irq_enable) begin
            updAct <= 1'b0;
        end else if (updEv) begin
            updAct <= 1'b1;
            updRel <= update_period_sel ? rtcfl_pkg::REL_W'(RELEASE_SHORT_CYC)
                                        : rtcfl_pkg::REL_W'(RELEASE_LONG_CYC);
        end else if (updAct) begin
            updRel <= updRel - 24'h000001;
            if (updRel == 24'h000001) begin
                updAct <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tmrAct <= 1'b0;
            tmrRel <= '0;
        end else if (!countdown_irq_enable) begin
            tmrAct <= 1'b0;
        end else if (tmrEv) begin
            tmrAct <= 1'b1;
            tmrRel <= rtcfl_pkg::REL_W'(RELEASE_SHORT_CYC);
        end else if (tmrAct) begin
            tmrRel <= tmrRel - 24'h000001;
            if (tmrRel == 24'h000001) begin
                tmrAct <= 1'b0;
            end
        end
    end

    // alarm holds the pin until its flag or its enable is cleared
    assign almAct = alarm_irq_enable && event_flags[rtcfl_pkg::FLG_ALM];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            intPinOe <= 1'b0;
        end else begin
            intPinOe <= updAct | tmrAct | almAct;
        end
    end

    assign intPinOut = 1'b0;

endmodule

// >>> tb/rtcfl_core_chk.sv
`timescale 1ns/1ps
module rtcfl_core_chk #(
    parameter int unsigned RELEASE_LONG_CYC = 40,
    parameter int unsigned RELEASE_SHORT_CYC = 10
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // register bus
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // pins
    input wire logic alarmMatch,
    input wire logic intPinOut,
    input wire logic intPinOe,
    input wire logic clock_out_pin
);
    logic acc;
    logic [3:0] idx;
    logic [7:0] ctrlSh;
    logic [1:0] freqSh;
    logic [10:0] quiet;
    logic lastClk;
    assign acc = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign idx = avs_address[5:2];
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // ----------------------------------------
    // shadows of the written control fields
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) ctrlSh <= rtcfl_pkg::CTRL_RST;
        else if (acc && idx == rtcfl_pkg::IDX_CTRL) ctrlSh <= avs_writedata[7:0];
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) freqSh <= 2'h0;
        else if (acc && idx == rtcfl_pkg::IDX_EXT) freqSh <= avs_writedata[3:2];
    end
    // cycles since the clock output last moved; any accepted write with byte enable 0 set restarts it
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            quiet <= 11'h000;
            lastClk <= 1'b0;
        end else begin
            lastClk <= clock_out_pin;
            if (clock_out_pin != lastClk || acc) quiet <= 11'h000;
            else if (quiet != 11'h7FF) quiet <= quiet + 11'h001;
        end
    end

    a_flag_top_zero: assert property (avs_read && !avs_waitrequest && idx == 4'hE
        |-> avs_readdata[7:6] == 2'h0) else $error("flag bits 7:6 not zero");
    a_ctrl_echo: assert property (avs_read && !avs_waitrequest && idx == 4'hF
        |-> avs_readdata[7:0] == (ctrlSh & 8'hFD)) else $error("control readback wrong");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest && idx < 4'hB
        |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
    a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("wait state count wrong");
    a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data changed without read");
    a_pin_gated: assert property ($rose(intPinOe) |-> ctrlSh[5:3] != 3'h0)
        else $error("pin asserted with sources disabled");
    a_pin_off: assert property ((ctrlSh[5:3] == 3'h0) [*3] |-> !intPinOe)
        else $error("pin held with sources disabled");
    a_alarm_pin: assert property ($rose(alarmMatch) && ctrlSh[3] |-> ##[1:8] intPinOe)
        else $error("alarm did not drive pin");
    a_od_low: assert property (!intPinOut)
        else $error("open drain data not low");
    a_clk_fast: assert property (freqSh[0] == freqSh[1] && !ctrlSh[0]
        |-> quiet < 11'h320) else $error("fast clock output stalled");
endmodule

bind rtcfl_core rtcfl_core_chk #(
    .RELEASE_LONG_CYC(RELEASE_LONG_CYC),
    .RELEASE_SHORT_CYC(RELEASE_SHORT_CYC)
) u_rtcfl_core_chk (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .alarmMatch, .intPinOut, .intPinOe,
    .clock_out_pin);

// >>> tb/rtcfl_host.sv
`timescale 1ns/1ps
module rtcfl_host (
    // pin from the device
    input wire logic intPinOut,
    input wire logic intPinOe,
    // level seen by the host; pull-up wins when released
    output logic intN
);
    assign intN = intPinOe ? intPinOut : 1'b1;
endmodule

// >>> tb/rtc_control_flag_regs_tb.sv
`timescale 1ns/1ps
module rtc_control_flag_regs_tb;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    // alarm, event, loss, comp-stop
    logic [3:0] evIn = 4'h0;
    logic intPinOut, intPinOe, clock_out_pin, compStrobe, clockResetActive, alarmDaySel, intN;
    logic [7:0] rdata, want;
    logic last;
    logic [1:0] fs [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
    int err_total = 0;
    int total_checks = 0;
    int n, t;

    initial forever #20 sys_clk = ~sys_clk;

    rtcfl_core #(.RELEASE_LONG_CYC(40), .RELEASE_SHORT_CYC(10)) u_rtcfl_core (
        .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .alarmMatch(evIn[0]), .eventIn(evIn[1]), .dataLossIn(evIn[2]), .compStopIn(evIn[3]),
        .intPinOut(intPinOut), .intPinOe(intPinOe), .clock_out_pin(clock_out_pin),
        .compStrobe(compStrobe), .clockResetActive(clockResetActive), .alarmDaySel(alarmDaySel));
    rtcfl_host u_rtcfl_host (.intPinOut(intPinOut), .intPinOe(intPinOe), .intN(intN));

    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    task automatic bus(input logic wr, input logic [3:0] idx, input logic [7:0] d,
        input logic [3:0] be);
        @(posedge sys_clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h000000, d};
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        // look before the edge so the edge itself is the accepting one
        do @(negedge sys_clk); while (avs_waitrequest !== 1'b0);
        @(posedge sys_clk);
        rdata = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d, 4'hF);
    endtask
    task automatic rd(input logic [3:0] idx, input logic [7:0] exp, input string nm);
        bus(1'b0, idx, 8'h00, 4'hF);
        chk(nm, exp, rdata);
    endtask
    task automatic fire(input int b);
        @(posedge sys_clk);
        evIn[b] <= 1'b1;
        repeat (6) @(posedge sys_clk);
        evIn[b] <= 1'b0;
        repeat (6) @(negedge sys_clk);
    endtask
    task automatic end_sim();
        if (err_total == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge sys_clk);
        err_total++;
        end_sim();
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(rtcfl_pkg::IDX_FLAG, 8'h03, "flags_rst");
        rd(rtcfl_pkg::IDX_CTRL, 8'h40, "ctrl_rst");
        rd(rtcfl_pkg::IDX_EXT, 8'h00, "ext_rst");
        rd(4'h3, 8'h00, "unmapped");
        wr(rtcfl_pkg::IDX_FLAG, 8'hFF);
        rd(rtcfl_pkg::IDX_FLAG, 8'h03, "flags_w1");
        // check the write masks, then restore extension and control before clearing the loss flag
        wr(rtcfl_pkg::IDX_EXT, 8'hFF);
        rd(rtcfl_pkg::IDX_EXT, 8'h7F, "ext_mask");
        chk("day_sel", 8'h01, {7'h00, alarmDaySel});
        wr(rtcfl_pkg::IDX_CTRL, 8'hFF);
        rd(rtcfl_pkg::IDX_CTRL, 8'hFD, "ctrl_mask");
        chk("clk_reset", 8'h01, {7'h00, clockResetActive});
        bus(1'b1, rtcfl_pkg::IDX_CTRL, 8'h00, 4'hE);
        rd(rtcfl_pkg::IDX_CTRL, 8'hFD, "ctrl_be");
        wr(rtcfl_pkg::IDX_EXT, 8'h00);
        wr(rtcfl_pkg::IDX_CTRL, 8'h40);
        wr(rtcfl_pkg::IDX_FLAG, 8'h00);
        rd(rtcfl_pkg::IDX_FLAG, 8'h00, "flags_clr");
        chk("clk_run", 8'h00, {7'h00, clockResetActive});
        chk("day_clr", 8'h00, {7'h00, alarmDaySel});
        want = 8'h00;
        for (int b = 0; b < 4; b++) begin
            fire(b);
            want = want | (8'h01 << (3 - b));
            rd(rtcfl_pkg::IDX_FLAG, want, "flag_evt");
            chk("pin_idle", 8'h01, {7'h00, intN});
        end
        wr(rtcfl_pkg::IDX_FLAG, 8'hF7);
        rd(rtcfl_pkg::IDX_FLAG, 8'h07, "flag_af_clr");
        wr(rtcfl_pkg::IDX_FLAG, 8'h00);
        wr(rtcfl_pkg::IDX_CTRL, 8'h48);
        fire(0);
        chk("pin_alarm", 8'h00, {7'h00, intN});
        wr(rtcfl_pkg::IDX_CTRL, 8'h44);
        repeat (3) @(negedge sys_clk);
        chk("pin_cancel", 8'h01, {7'h00, intN});
        wr(rtcfl_pkg::IDX_FLAG, 8'h00);
        fire(1);
        chk("pin_evt", 8'h01, {7'h00, intN});
        rd(rtcfl_pkg::IDX_FLAG, 8'h04, "flag_evt_only");
        wr(rtcfl_pkg::IDX_FLAG, 8'h00);
        // timer: preset 2 at 4096 Hz lands between 6104 and 12208 cycles
        wr(rtcfl_pkg::IDX_TMR_LO, 8'h02);
        wr(rtcfl_pkg::IDX_TMR_HI, 8'h00);
        wr(rtcfl_pkg::IDX_CTRL, 8'h50);
        wr(rtcfl_pkg::IDX_EXT, 8'h10);
        n = 0;
        while (intN !== 1'b0 && n < 13000) begin
            @(negedge sys_clk);
            n++;
        end
        chk("tmr_time", 8'h01, {7'h00, n > 6000 && n < 12300});
        repeat (15) @(negedge sys_clk);
        chk("tmr_release", 8'h01, {7'h00, intN});
        rd(rtcfl_pkg::IDX_FLAG, 8'h10, "flag_tmr");
        wr(rtcfl_pkg::IDX_EXT, 8'h00);
        wr(rtcfl_pkg::IDX_FLAG, 8'h00);
        repeat (14000) @(posedge sys_clk);
        rd(rtcfl_pkg::IDX_FLAG, 8'h00, "tmr_stop");
        last = clock_out_pin;
        foreach (fs[i]) begin
            wr(rtcfl_pkg::IDX_EXT, {4'h0, fs[i], 2'b00});
            t = 0;
            repeat (fs[i] == 2'h1 ? 13000 : 2000) begin
                @(negedge sys_clk);
                t += int'(clock_out_pin !== last);
                last = clock_out_pin;
            end
            if (fs[i] == 2'h1) chk("clkout_1k", 8'h01, {7'h00, t >= 1 && t <= 2});
            else chk("clkout", 8'h01, {7'h00, fs[i] == 2'h2 ? t <= 1 : t >= 4 && t <= 7});
        end
        end_sim();
    end
endmodule
